// *** include/vpic_defines.svh ***
// register offsets, field positions, response codes for the vectored interrupt controller
`ifndef VPIC_DEFINES_SVH
`define VPIC_DEFINES_SVH
`define VPIC_NSRC          32
`define VPIC_MODE_BASE     12'h000
`define VPIC_VEC_BASE      12'h080
`define VPIC_CUR_VEC       12'h100
`define VPIC_FAST_VEC      12'h104
`define VPIC_STATUS        12'h108
`define VPIC_PENDING       12'h10c
`define VPIC_MASK          12'h110
`define VPIC_CORE_STAT     12'h114
`define VPIC_EN_CMD        12'h120
`define VPIC_DIS_CMD       12'h124
`define VPIC_CLR_CMD       12'h128
`define VPIC_SET_CMD       12'h12c
`define VPIC_END_CMD       12'h130
`define VPIC_SPUR_VEC      12'h134
`define VPIC_DEBUG         12'h138
`define VPIC_FAST_FORCE_EN 12'h140
`define VPIC_FAST_FORCE_DI 12'h144
`define VPIC_FAST_FORCE_ST 12'h148
`define VPIC_PRIO_LSB      0
`define VPIC_TYPE_LSB      5
`define VPIC_DBG_PROT      0
`define VPIC_DBG_GMSK      1
`define VPIC_RESP_OKAY     2'h0
`define VPIC_RESP_SLVERR   2'h2
`endif

// *** include/vpic_pkg.sv ***
// types shared by the vectored interrupt controller
package vpic_pkg;
  // trigger_type_field encodings
  typedef enum logic [1:0] {
    VPIC_LVL_LOW_INT = 2'h0,
    VPIC_EDGE_NEG    = 2'h1,
    VPIC_LVL_HIGH    = 2'h2,
    VPIC_EDGE_POS    = 2'h3
  } vpic_trig_e;
  // source_mode_reg content
  typedef struct packed {
    vpic_trig_e trig;
    logic [2:0] prio;
  } vpic_mode_s;
  // result of the priority resolver
  typedef struct packed {
    logic       hit;
    logic [4:0] src;
    logic [2:0] prio;
  } vpic_pick_s;
endpackage

// *** hw/vpic_top.sv ***
// vectored priority interrupt controller with axi4-lite register slave
//
// Overview of operation
// - up to 32 sources, each individually maskable with its own vector
// - source 0 is only the fast interrupt pin
// - source 1 is the combined system peripheral request
// - sources 2 to 31 are peripheral or external lines
// - eight-level resolver over sources 1 to 31 drives normal request
// - higher pending priority still raises normal request during service
// - internal sources are level or edge triggered
// - external sources rise, fall, high or low sensitive
// - redirected sources drive the fast request instead of normal
// - one 32-bit software vector per source
// - current vector read returns the winning source vector, else the spurious vector
// - protect mode suppresses read side effects
// - general mask keeps request lines idle while events still seen
// - two active-low outputs, fast and normal request
// - priority 7 highest down to 0 lowest
// - equal top priority resolves to lowest source number
// - current vector read clears edge memory unless redirected
// - set and clear commands act only on edge sources
`timescale 1ns/1ns
`include "vpic_defines.svh"
module vpic_top #(
  parameter int          NSRC     = `VPIC_NSRC,
  parameter logic [31:0] EXT_MASK = 32'hfffffffc   // sources wired to external pins
) (
  input  wire logic             sys_clk_i,       // system clock
  input  wire logic             rst_b_i,         // synchronous reset, active low
  input  wire logic             fast_interrupt_pin_i, // source 0 pin
  input  wire logic             sys_periph_irq_i,     // source 1, or of system peripherals
  input  wire logic [NSRC-1:2]  external_interrupt_pins_i, // sources 2 up
  input  wire logic [11:0]      s_axi_awaddr,    // write address
  input  wire logic             s_axi_awvalid,   // write address valid
  output logic                  s_axi_awready,   // write address ready
  input  wire logic [31:0]      s_axi_wdata,     // write data
  input  wire logic [3:0]       s_axi_wstrb,     // write strobes
  input  wire logic             s_axi_wvalid,    // write data valid
  output logic                  s_axi_wready,    // write data ready
  output logic [1:0]            s_axi_bresp,     // write response
  output logic                  s_axi_bvalid,    // write response valid
  input  wire logic             s_axi_bready,    // write response ready
  input  wire logic [11:0]      s_axi_araddr,    // read address
  input  wire logic             s_axi_arvalid,   // read address valid
  output logic                  s_axi_arready,   // read address ready
  output logic [31:0]           s_axi_rdata,     // read data
  output logic [1:0]            s_axi_rresp,     // read response
  output logic                  s_axi_rvalid,    // read data valid
  input  wire logic             s_axi_rready,    // read data ready
  output logic                  fast_request_out_n,   // fast request, active low
  output logic                  normal_request_out_n  // normal request, active low
);

  // refuse source counts that the five-bit source index cannot serve
  if (NSRC < 3 || NSRC > 32) begin : g_bad_nsrc
    $error("NSRC must be 3 to 32");
  end

  // ----------------------------------------------------------------
  // source conditioning
  // ----------------------------------------------------------------
  vpic_pkg::vpic_mode_s mode_reg [NSRC];
  logic [31:0]          vec_reg  [NSRC];
  logic [NSRC-1:0]      raw;
  logic [NSRC-1:0]      raw_d_reg;
  logic [NSRC-1:0]      is_edge;
  logic [NSRC-1:0]      cond;
  logic [NSRC-1:0]      edge_reg;
  logic [NSRC-1:0]      pend;
  logic [NSRC-1:0]      mask_reg;
  logic [NSRC-1:0]      ffe_reg;
  logic [NSRC-1:0]      edge_set;
  logic [NSRC-1:0]      edge_clr;
  logic [NSRC-1:0]      sw_set;
  logic [NSRC-1:0]      sw_clr;
  logic                 prot_reg;
  logic                 gmask_reg;
  logic [31:0]          spur_reg;

  // fast pin, system or, remaining lines
  assign raw = {external_interrupt_pins_i, sys_periph_irq_i, fast_interrupt_pin_i};

  for (genvar i = 0; i < NSRC; i++) begin : g_src
    logic ext;
    assign ext = EXT_MASK[i] | (i == 0);
    assign is_edge[i] = mode_reg[i].trig[0];
    always_comb begin
      unique case (mode_reg[i].trig)
        vpic_pkg::VPIC_LVL_LOW_INT: cond[i] = ext ? ~raw[i] : raw[i];
        vpic_pkg::VPIC_EDGE_NEG:    cond[i] = ext ? (raw_d_reg[i] & ~raw[i])
                                                  : (raw[i] & ~raw_d_reg[i]);
        vpic_pkg::VPIC_LVL_HIGH:    cond[i] = raw[i];
        vpic_pkg::VPIC_EDGE_POS:    cond[i] = raw[i] & ~raw_d_reg[i];
      endcase
    end
    assign edge_set[i] = (is_edge[i] & cond[i]) | (is_edge[i] & sw_set[i]);
    assign pend[i] = is_edge[i] ? edge_reg[i] : cond[i];
  end

  // previous input sample for edge detection
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) raw_d_reg <= '0;
    else          raw_d_reg <= raw;
  end

  // edge memory, set wins over clear
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) edge_reg <= '0;
    else          edge_reg <= edge_set | (edge_reg & ~(edge_clr & is_edge));
  end

  // ----------------------------------------------------------------
  // priority resolver and service stack
  // ----------------------------------------------------------------
  logic [NSRC-1:0]      act_norm;
  vpic_pkg::vpic_pick_s pick;
  logic [2:0]           stk_prio_reg [8];
  logic [4:0]           stk_src_reg  [8];
  logic [3:0]           depth_reg;
  logic                 ivr_take;
  logic                 eoi;
  logic [2:0]           cur_prio;
  logic                 pick_win;

  // masking, redirected sources leave the normal path
  assign act_norm = pend & mask_reg & ~ffe_reg & {{(NSRC-1){1'b1}}, 1'b0};
  assign cur_prio = stk_prio_reg[depth_reg[2:0] - 3'h1];
  // the pick only counts when it beats the level in service
  assign pick_win = pick.hit && (depth_reg == 4'h0 || pick.prio > cur_prio);

  // highest level wins, lowest number on ties
  function automatic vpic_pkg::vpic_pick_s resolve(input logic [NSRC-1:0] act);
    vpic_pkg::vpic_pick_s p;
    p = '0;
    for (int k = NSRC - 1; k >= 1; k--) begin
      if (act[k] && (!p.hit || mode_reg[k].prio >= p.prio)) begin
        p.hit  = 1'b1;
        p.src  = 5'(k);
        p.prio = mode_reg[k].prio;
      end
    end
    return p;
  endfunction

  // process form so that a priority change alone also re-runs the resolver
  always_comb pick = resolve(act_norm);

  // push on vector read, pop on end of service
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      depth_reg <= 4'h0;
      for (int k = 0; k < 8; k++) begin
        stk_prio_reg[k] <= 3'h0;
        stk_src_reg[k]  <= 5'h0;
      end
    end else if (ivr_take && pick_win && depth_reg < 4'h8) begin
      stk_prio_reg[depth_reg[2:0]] <= pick.prio;
      stk_src_reg[depth_reg[2:0]]  <= pick.src;
      depth_reg <= depth_reg + 4'h1;
    end else if (eoi && depth_reg != 4'h0) begin
      depth_reg <= depth_reg - 4'h1;
    end
  end

  // request when idle or a higher level waits; general mask; active low
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      normal_request_out_n <= 1'b1;
      fast_request_out_n   <= 1'b1;
    end else begin
      normal_request_out_n <= ~(pick_win && !gmask_reg);
      // fast line from source 0 and redirected sources
      fast_request_out_n   <= ~(|(pend & mask_reg & (ffe_reg | {{(NSRC-1){1'b0}}, 1'b1}))
                                && !gmask_reg);
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  logic [11:0] awa_reg;
  logic        awh_reg;
  logic [31:0] wd_reg;
  logic        wh_reg;
  logic        wr_go;
  logic        rd_go;
  logic [4:0]  widx;
  logic [31:0] rval;
  logic        rok;
  logic        wok;

  assign s_axi_awready = !awh_reg && !s_axi_bvalid;
  assign s_axi_wready  = !wh_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go = awh_reg && wh_reg && !s_axi_bvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign widx  = awa_reg[6:2];

  // address and data capture in either order
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      awh_reg <= 1'b0;
      wh_reg  <= 1'b0;
      awa_reg <= 12'h000;
      wd_reg  <= 32'h0;
    end else if (wr_go) begin
      awh_reg <= 1'b0;
      wh_reg  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awh_reg <= 1'b1;
        awa_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wh_reg <= 1'b1;
        for (int b = 0; b < 4; b++) begin
          wd_reg[8*b +: 8] <= s_axi_wstrb[b] ? s_axi_wdata[8*b +: 8] : 8'h00;
        end
      end
    end
  end

  // write decode, full word registers and command strobes
  always_comb begin
    wok    = 1'b1;
    sw_set = '0;
    sw_clr = '0;
    eoi    = 1'b0;
    if (wr_go) begin
      unique case (awa_reg)
        `VPIC_SET_CMD: sw_set = wd_reg[NSRC-1:0];
        `VPIC_CLR_CMD: sw_clr = wd_reg[NSRC-1:0];
        `VPIC_END_CMD: eoi    = 1'b1;
        `VPIC_EN_CMD, `VPIC_DIS_CMD, `VPIC_SPUR_VEC, `VPIC_DEBUG,
        `VPIC_FAST_FORCE_EN, `VPIC_FAST_FORCE_DI: wok = 1'b1;
        default: wok = (awa_reg[11:8] == 4'h0) && (awa_reg[1:0] == 2'h0) &&
                       (int'(widx) < NSRC);
      endcase
    end
  end

  // auto clear of selected edge source unless protected or redirected
  assign edge_clr = sw_clr |
                    ((ivr_take && pick_win) ? (NSRC'(1) << pick.src) : '0) |
                    ((rd_go && s_axi_araddr == `VPIC_FAST_VEC && !prot_reg) ? NSRC'(1) : '0);

  // mask, redirection, general mask, protect, spurious vector
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      mask_reg  <= '0;
      ffe_reg   <= '0;
      prot_reg  <= 1'b0;
      gmask_reg <= 1'b0;
      spur_reg  <= 32'h0;
    end else if (wr_go) begin
      if (awa_reg == `VPIC_EN_CMD)        mask_reg <= mask_reg | wd_reg[NSRC-1:0];
      if (awa_reg == `VPIC_DIS_CMD)       mask_reg <= mask_reg & ~wd_reg[NSRC-1:0];
      if (awa_reg == `VPIC_FAST_FORCE_EN) ffe_reg  <= ffe_reg | (wd_reg[NSRC-1:0] & ~NSRC'(1));
      if (awa_reg == `VPIC_FAST_FORCE_DI) ffe_reg  <= ffe_reg & ~wd_reg[NSRC-1:0];
      if (awa_reg == `VPIC_SPUR_VEC)      spur_reg <= wd_reg;
      if (awa_reg == `VPIC_DEBUG) begin
        prot_reg  <= wd_reg[`VPIC_DBG_PROT];
        gmask_reg <= wd_reg[`VPIC_DBG_GMSK];
      end
    end
  end

  // vectors and source modes, reset to level low/internal level at priority 0
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      for (int k = 0; k < NSRC; k++) begin
        mode_reg[k] <= '0;
        vec_reg[k]  <= 32'h0;
      end
    end else if (wr_go && awa_reg[11:8] == 4'h0 && awa_reg[1:0] == 2'h0 &&
                 int'(widx) < NSRC) begin
      if (!awa_reg[7]) mode_reg[widx] <= vpic_pkg::vpic_mode_s'(wd_reg[4:0]);
      else             vec_reg[widx]  <= wd_reg;
    end
  end

  // write response
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `VPIC_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wok ? `VPIC_RESP_OKAY : `VPIC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // current vector read takes the resolver result as the service entry
  assign ivr_take = rd_go && s_axi_araddr == `VPIC_CUR_VEC && !prot_reg;

  // read mux
  always_comb begin
    rok  = 1'b1;
    rval = 32'h0;
    unique case (s_axi_araddr)
      `VPIC_CUR_VEC:   rval = pick_win ? vec_reg[pick.src] : spur_reg;
      `VPIC_FAST_VEC:  rval = vec_reg[0];
      `VPIC_STATUS:    rval = {27'h0, (depth_reg == 4'h0) ? 5'h0
                                      : stk_src_reg[depth_reg[2:0] - 3'h1]};
      `VPIC_PENDING:   rval = 32'(pend);
      `VPIC_MASK:      rval = 32'(mask_reg);
      `VPIC_CORE_STAT: rval = {30'h0, ~normal_request_out_n, ~fast_request_out_n};
      `VPIC_SPUR_VEC:  rval = spur_reg;
      `VPIC_DEBUG:     rval = {30'h0, gmask_reg, prot_reg};
      `VPIC_FAST_FORCE_ST: rval = 32'(ffe_reg);
      default: begin
        if (s_axi_araddr[11:8] == 4'h0 && s_axi_araddr[1:0] == 2'h0 &&
            int'(s_axi_araddr[6:2]) < NSRC) begin
          rval = s_axi_araddr[7] ? vec_reg[s_axi_araddr[6:2]]
                                 : 32'(mode_reg[s_axi_araddr[6:2]]);
        end else begin
          rok = 1'b0;
        end
      end
    endcase
  end

  // read response registers
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `VPIC_RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rval;
      s_axi_rresp  <= rok ? `VPIC_RESP_OKAY : `VPIC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// *** bench/vpic_top_properties.sv ***
// concurrent checks on the ports of the interrupt controller
`timescale 1ns/1ns
module vpic_top_checker (
  input wire logic        sys_clk_i,            // system clock
  input wire logic        rst_b_i,              // synchronous reset, active low
  input wire logic        s_axi_awvalid,        // write address valid
  input wire logic        s_axi_awready,        // write address ready
  input wire logic        s_axi_wvalid,         // write data valid
  input wire logic        s_axi_wready,         // write data ready
  input wire logic [1:0]  s_axi_bresp,          // write response
  input wire logic        s_axi_bvalid,         // write response valid
  input wire logic        s_axi_bready,         // write response ready
  input wire logic        s_axi_arvalid,        // read address valid
  input wire logic        s_axi_arready,        // read address ready
  input wire logic [31:0] s_axi_rdata,          // read data
  input wire logic        s_axi_rvalid,         // read data valid
  input wire logic        s_axi_rready,         // read data ready
  input wire logic        fast_request_out_n,   // fast request, active low
  input wire logic        normal_request_out_n  // normal request, active low
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  // both request lines come out of reset released
  chk_reset_lines_idle: assert property ($rose(rst_b_i) |->
    fast_request_out_n && normal_request_out_n) else $error("request line low after reset");
  // a write taken on both channels is answered within three cycles
  chk_write_answered: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("write not answered");
  chk_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  chk_bvalid_ends: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  chk_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  // read data follows the taken address by one cycle
  chk_read_answered: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  chk_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  chk_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
endmodule
bind vpic_top vpic_top_checker u_chk (.sys_clk_i, .rst_b_i, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .fast_request_out_n,
  .normal_request_out_n);

// *** bench/vpic_core_model.sv ***
// processor core model that counts the cycles each request line is asserted
`timescale 1ns/1ns
module vpic_core_model (
  input wire logic sys_clk_i,  // system clock
  input wire logic rst_b_i,    // synchronous reset, active low
  input wire logic fast_n_i,   // fast request, active low
  input wire logic normal_n_i, // normal request, active low
  output int       fast_cnt_o, // cycles with fast request seen
  output int       norm_cnt_o  // cycles with normal request seen
);
  // a low level is a request
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      fast_cnt_o <= 0;
      norm_cnt_o <= 0;
    end else begin
      fast_cnt_o <= fast_cnt_o + int'(fast_n_i === 1'b0);
      norm_cnt_o <= norm_cnt_o + int'(normal_n_i === 1'b0);
    end
  end
endmodule

// *** bench/tb_vectored_priority_interrupt_controller.sv ***
// self-checking bench for the vectored interrupt controller
`timescale 1ns/1ns
`include "vpic_defines.svh"
module tb_vectored_priority_interrupt_controller;
  logic sys_clk_i, rst_b_i, fast_interrupt_pin_i, sys_periph_irq_i;
  logic [31:2] external_interrupt_pins_i;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rd_resp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic fast_request_out_n, normal_request_out_n;
  logic [31:0] vec [32];
  logic [31:0] spur;
  int n_fail, n_compared, fast_cnt, norm_cnt, i;
  vpic_top dut (.sys_clk_i, .rst_b_i, .fast_interrupt_pin_i, .sys_periph_irq_i,
    .external_interrupt_pins_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .fast_request_out_n, .normal_request_out_n);
  vpic_core_model u_core (.sys_clk_i, .rst_b_i, .fast_n_i(fast_request_out_n),
    .normal_n_i(normal_request_out_n), .fast_cnt_o(fast_cnt), .norm_cnt_o(norm_cnt));
  always #4 sys_clk_i = ~sys_clk_i;
  task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // source mode word: trigger type above the priority level
  function automatic logic [31:0] mode_word(input logic [1:0] t, input logic [2:0] p);
    return {27'h0, t, p};
  endfunction
  task idle(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  // one bus transfer, write when w is set; ready and answers sampled before the edge
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    logic ta, tw, tr, done;
    int k;
    @(posedge sys_clk_i);
    if (w) begin
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
      s_axi_bready <= 1;
    end else begin
      s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    end
    done = 0;
    for (k = 0; k < 40 && !done; k++) begin
      @(negedge sys_clk_i);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tr = s_axi_arvalid && s_axi_arready;
      done = w ? (s_axi_bvalid === 1'b1) : (s_axi_rvalid === 1'b1);
      rd_data = s_axi_rdata;
      rd_resp = w ? s_axi_bresp : s_axi_rresp;
      @(posedge sys_clk_i);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
      if (tr) s_axi_arvalid <= 0;
      if (done) begin
        s_axi_bready <= 0; s_axi_rready <= 0;
      end
    end
    if (!done) begin
      n_fail++;
      $display("[ERR] bus_timeout expected answer seen none");
      print_verdict;
    end
  endtask
  task req(input logic f, input logic nrm);
    idle(4);
    chk("fast_req", f, fast_request_out_n);
    chk("normal_req", nrm, normal_request_out_n);
  endtask
  task cur(input logic [31:0] e);
    xfer(0, `VPIC_CUR_VEC, 0);
    chk("cur_vec", e, rd_data);
  endtask
  initial begin
    sys_clk_i = 0; rst_b_i = 0; fast_interrupt_pin_i = 0; sys_periph_irq_i = 0;
    external_interrupt_pins_i = '0; s_axi_awaddr = '0; s_axi_araddr = '0; s_axi_wdata = '0;
    s_axi_wstrb = 4'hf; s_axi_awvalid = 0; s_axi_wvalid = 0; s_axi_bready = 0;
    s_axi_arvalid = 0; s_axi_rready = 0; n_fail = 0; n_compared = 0;
    void'($urandom(88834));
    repeat (16) @(posedge sys_clk_i);
    rst_b_i <= 1;
    req(1, 1);
    for (i = 0; i < 32; i++) begin
      vec[i] = $urandom;
      xfer(1, `VPIC_VEC_BASE + 12'(4 * i), vec[i]);
    end
    for (i = 0; i < 32; i += 5) begin
      xfer(0, `VPIC_VEC_BASE + 12'(4 * i), 0);
      chk("vector", vec[i], rd_data);
    end
    xfer(0, 12'hffc, 0);
    chk("unmapped_resp", `VPIC_RESP_SLVERR, rd_resp);
    spur = $urandom;
    xfer(1, `VPIC_SPUR_VEC, spur);
    xfer(1, `VPIC_MODE_BASE, 32'h10);
    xfer(1, `VPIC_MODE_BASE + 12'h014, 32'h1b);
    xfer(1, `VPIC_MODE_BASE + 12'h024, 32'h13);
    xfer(1, `VPIC_MODE_BASE + 12'h030, 32'h16);
    xfer(1, `VPIC_EN_CMD, 32'h00001221);
    // equal priority edge and level sources raised together
    @(posedge sys_clk_i);
    external_interrupt_pins_i[5] <= 1;
    external_interrupt_pins_i[9] <= 1;
    req(1, 0);
    cur(vec[5]);
    req(1, 1);
    xfer(1, `VPIC_END_CMD, 0);
    req(1, 0);
    cur(vec[9]);
    // higher priority source preempts the one in service
    @(posedge sys_clk_i);
    external_interrupt_pins_i[12] <= 1;
    req(1, 0);
    cur(vec[12]);
    xfer(1, `VPIC_FAST_FORCE_EN, 32'h00001000);
    xfer(1, `VPIC_END_CMD, 0);
    xfer(1, `VPIC_END_CMD, 0);
    external_interrupt_pins_i[9] <= 0;
    req(0, 1);
    xfer(1, `VPIC_DEBUG, 32'h2);
    req(1, 1);
    xfer(1, `VPIC_DEBUG, 32'h0);
    xfer(1, `VPIC_FAST_FORCE_DI, 32'h00001000);
    external_interrupt_pins_i[12] <= 0;
    fast_interrupt_pin_i <= 1;
    req(0, 1);
    @(posedge sys_clk_i);
    fast_interrupt_pin_i <= 0;
    xfer(1, `VPIC_SET_CMD, 32'h00000200);
    req(1, 1);
    xfer(1, `VPIC_SET_CMD, 32'h00000020);
    req(1, 0);
    xfer(1, `VPIC_CLR_CMD, 32'h00000020);
    req(1, 1);
    // protected reads leave the pending edge in place
    xfer(1, `VPIC_SET_CMD, 32'h00000020);
    xfer(1, `VPIC_DEBUG, 32'h1);
    cur(vec[5]);
    cur(vec[5]);
    req(1, 0);
    xfer(1, `VPIC_DEBUG, 32'h0);
    cur(vec[5]);
    cur(spur);
    xfer(1, `VPIC_END_CMD, 0);
    // falling edge on an external line, with register read-back around it
    xfer(1, `VPIC_MODE_BASE + 12'h050, mode_word(2'h1, 3'h5));
    xfer(1, `VPIC_EN_CMD, 32'h00100000);
    xfer(0, `VPIC_MASK, 0);
    chk("mask", 32'h00101221, rd_data);
    external_interrupt_pins_i[20] <= 1;
    req(1, 1);
    @(posedge sys_clk_i);
    external_interrupt_pins_i[20] <= 0;
    req(1, 0);
    xfer(0, `VPIC_CORE_STAT, 0);
    chk("core_stat", 32'h00000002, rd_data);
    cur(vec[20]);
    xfer(0, `VPIC_STATUS, 0);
    chk("status", 32'h00000014, rd_data);
    req(1, 1);
    xfer(1, `VPIC_END_CMD, 0);
    xfer(0, `VPIC_FAST_VEC, 0);
    chk("fast_vec", vec[0], rd_data);
    xfer(1, 12'hffc, 0);
    chk("unmapped_wr_resp", `VPIC_RESP_SLVERR, rd_resp);
    chk("core_saw_both", 1, 32'(fast_cnt > 0 && norm_cnt > 0));
    print_verdict;
  end
endmodule
